// ### hw/ets_pkg.sv
// Package of constants and types for the event time-stamp capture block.
`default_nettype none

package ets_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ETS_OFS_EVENT_CONTROL    = 8'h13;
  localparam logic [7:0] ETS_OFS_EVENT_COUNTER    = 8'h14;
  localparam logic [7:0] ETS_OFS_CAPTURED_SECONDS = 8'h15;

  // ****************************************
  // Event control field positions
  // ****************************************
  localparam int ETS_BIT_SOURCE_SELECT    = 0;
  localparam int ETS_BIT_OVERWRITE_SELECT = 1;
  localparam int ETS_BIT_STAMP_CLEAR      = 2;
  localparam int ETS_BIT_FILTER_LO        = 4;
  localparam int ETS_BIT_FILTER_HI        = 5;
  localparam int ETS_BIT_LEVEL_SELECT     = 6;
  localparam int ETS_BIT_SECONDS_TOP      = 7;

  // ****************************************
  // Reset values and counter width
  // ****************************************
  localparam logic [7:0] ETS_RST_EVENT_CONTROL = 8'h00;
  localparam logic [7:0] ETS_RST_CAPTURE       = 8'h00;
  localparam logic [7:0] ETS_RST_READ_DATA     = 8'h00;
  localparam int         ETS_COUNTER_WIDTH     = 8;

  // ****************************************
  // Types
  // ****************************************
  // Calendar time as six BCD bytes, also used for the captured copy.
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } ets_cal_time_t;

  // One host register access.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ets_reg_req_t;

endpackage : ets_pkg

`default_nettype wire

// ### hw/ets_event_counter.sv
// Wrapping binary event counter with synchronous clear.
`timescale 1ns/10ps
`default_nettype none

module ets_event_counter
  import ets_pkg::*;
#(
  parameter int WIDTH = ETS_COUNTER_WIDTH
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             clear,
  input  wire logic             inc,
  output var  logic [WIDTH-1:0] count
);

  // The register map gives the counter one byte; nothing wider fits.
  if (WIDTH < 1 || WIDTH > 8) begin : g_width_check
    $error("ets_event_counter: WIDTH must be 1 to 8");
  end

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  // A clear in the same cycle as an event still counts that event, so it is not lost.
  always_comb begin
    count_next = clear ? '0 : count_reg;
    if (inc) begin
      count_next = count_next + WIDTH'(1);
    end
  end

  // Plain binary wrap from all ones back to zero happens by width truncation.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

endmodule : ets_event_counter

`default_nettype wire

// ### hw/ets_time_stamp.sv
// Event time-stamp capture logic with its control and read-back registers.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Writing clear bit zeroes counter and captures.
// - Clear bit returns to zero by itself.
// - Overwrite off keeps first event until flag cleared.
// - Overwrite on captures every event.
// - Source bit picks pin or backup switchover.
// - Capture and counting only while enable set.
// - Eight-bit binary counter wraps to zero.
// - Counter counts regardless of overwrite mode.
// - Counter and seconds registers ignore writes.
// - Captured seconds BCD, top bit zero.
module ets_time_stamp
  import ets_pkg::*;
#(
  parameter int CNT_WIDTH = ETS_COUNTER_WIDTH
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire ets_reg_req_t  reg_req,
  output var  logic [7:0]    reg_rdata,
  input  wire logic          stamp_enable,
  input  wire logic          event_input_pin,
  input  wire logic          backup_supply,
  input  wire ets_cal_time_t cal_time,
  input  wire logic          event_flag_clear,
  output var  logic          event_flag,
  output var  ets_cal_time_t captured_time,
  output var  logic [7:0]    event_counter
);

  if (CNT_WIDTH != ETS_COUNTER_WIDTH) begin : g_width_check
    $error("ets_time_stamp: the counter must be one full byte");
  end

  // ****************************************
  // Event detection
  // ****************************************
  logic       pin_q_reg;
  logic       backup_q_reg;
  logic       pin_edge;
  logic       backup_edge;
  logic       src_event;
  logic       count_event;
  logic       capture_event;
  logic [7:0] ctl_reg;
  logic       stamp_clear_reg;
  logic       event_flag_reg;

  // Previous input levels; the pin arrives already filtered and polarity-corrected.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_q_reg    <= 1'b0;
      backup_q_reg <= 1'b0;
    end else begin
      pin_q_reg    <= event_input_pin;
      backup_q_reg <= backup_supply;
    end
  end

  assign pin_edge    = event_input_pin & ~pin_q_reg;
  assign backup_edge = backup_supply & ~backup_q_reg;

  // The source bit decides which edge is an event; the other is ignored.
  assign src_event = ctl_reg[ETS_BIT_SOURCE_SELECT] ? backup_edge : pin_edge;

  // Counting ignores the overwrite mode, only the enable gates it.
  assign count_event = src_event & stamp_enable;

  // First-event mode is armed only while the flag is down.
  assign capture_event = count_event &
                         (ctl_reg[ETS_BIT_OVERWRITE_SELECT] | ~event_flag_reg);

  // ****************************************
  // Control register and self-clearing reset bit
  // ****************************************
  logic ctl_write;

  assign ctl_write = reg_req.wr && (reg_req.addr == ETS_OFS_EVENT_CONTROL);

  // Bit 7 and bit 3 are always zero; the clear bit lives in its own flop.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctl_reg <= ETS_RST_EVENT_CONTROL;
    end else if (ctl_write) begin
      ctl_reg <= {1'b0, reg_req.wdata[ETS_BIT_LEVEL_SELECT:ETS_BIT_FILTER_LO], 2'b00,
                  reg_req.wdata[ETS_BIT_OVERWRITE_SELECT:ETS_BIT_SOURCE_SELECT]};
    end
  end

  // Clearing takes one cycle, then the bit drops back by itself.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stamp_clear_reg <= 1'b0;
    end else begin
      stamp_clear_reg <= ctl_write & reg_req.wdata[ETS_BIT_STAMP_CLEAR];
    end
  end

  // ****************************************
  // Event flag
  // ****************************************
  // A new event beats a host clear in the same cycle so it is never lost.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      event_flag_reg <= 1'b0;
    end else if (count_event) begin
      event_flag_reg <= 1'b1;
    end else if (event_flag_clear) begin
      event_flag_reg <= 1'b0;
    end
  end

  assign event_flag = event_flag_reg;

  // ****************************************
  // Captured time
  // ****************************************
  ets_cal_time_t cap_reg;

  // All six fields load on one edge so they describe one instant.
  // An event coinciding with a clear wins, since it is newer than the clear.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cap_reg <= {6{ETS_RST_CAPTURE}};
    end else if (capture_event) begin
      cap_reg         <= cal_time;
      cap_reg.seconds <= {1'b0, cal_time.seconds[6:0]};
    end else if (stamp_clear_reg) begin
      cap_reg <= {6{ETS_RST_CAPTURE}};
    end
  end

  assign captured_time = cap_reg;

  // ****************************************
  // Event counter
  // ****************************************
  logic [CNT_WIDTH-1:0] count;

  ets_event_counter #(
    .WIDTH (CNT_WIDTH)
  ) u_counter (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (stamp_clear_reg),
    .inc      (count_event),
    .count    (count)
  );

  assign event_counter = count;

  // ****************************************
  // Read-back
  // ****************************************
  logic [7:0] rdata_reg;

  // Writes to the counter and seconds offsets have no path into storage.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= ETS_RST_READ_DATA;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        ETS_OFS_EVENT_CONTROL:    rdata_reg <= ctl_reg | {5'h00, stamp_clear_reg, 2'b00};
        ETS_OFS_EVENT_COUNTER:    rdata_reg <= count;
        ETS_OFS_CAPTURED_SECONDS: rdata_reg <= cap_reg.seconds;
        default:                  rdata_reg <= ETS_RST_READ_DATA;
      endcase
    end
  end

  assign reg_rdata = rdata_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_clear_zeroes_all: assert property (
    stamp_clear_reg && !count_event |=> count == 8'h00 && cap_reg == '0)
    else $error("clear did not zero counter and captures");

  a_clear_self_ends: assert property (
    ctl_write && reg_req.wdata[ETS_BIT_STAMP_CLEAR] ##1 !ctl_write |=> !stamp_clear_reg)
    else $error("clear bit did not drop by itself");

  a_first_event_kept: assert property (
    count_event && !ctl_reg[ETS_BIT_OVERWRITE_SELECT] && event_flag_reg && !stamp_clear_reg
    |=> $stable(cap_reg))
    else $error("first-event capture was overwritten");

  a_overwrite_captures: assert property (
    count_event && ctl_reg[ETS_BIT_OVERWRITE_SELECT]
    |=> cap_reg.minutes == $past(cal_time.minutes) && cap_reg.year == $past(cal_time.year))
    else $error("overwrite mode missed an event");

  a_source_ignored: assert property (
    stamp_enable && !src_event && (pin_edge || backup_edge) && !stamp_clear_reg
    |=> $stable(count))
    else $error("unselected source changed the counter");

  a_disabled_holds: assert property (
    !stamp_enable && !stamp_clear_reg |=> $stable(count) && $stable(cap_reg))
    else $error("activity while stamping disabled");

  a_count_wraps: assert property (
    count_event && !stamp_clear_reg |=> count == 8'($past(count) + 8'h01))
    else $error("counter did not step by one");

  a_ro_write_ignored: assert property (
    reg_req.wr && reg_req.addr != ETS_OFS_EVENT_CONTROL && !count_event && !stamp_clear_reg
    |=> $stable(count) && $stable(cap_reg))
    else $error("write changed a read-only register");

  a_seconds_top_zero: assert property (
    cap_reg.seconds[ETS_BIT_SECONDS_TOP] == 1'b0)
    else $error("captured seconds top bit set");

  a_capture_coherent: assert property (
    capture_event |=> cap_reg.hours == $past(cal_time.hours) &&
                      cap_reg.date == $past(cal_time.date) &&
                      cap_reg.month == $past(cal_time.month))
    else $error("captured fields not from one instant");

  // ****************************************
  // Event flag checks
  // ****************************************
  // The flag is what re-arms first-event capture, so it must never miss an event.
  a_flag_sets: assert property (
    count_event |=> event_flag_reg)
    else $error("enabled event did not raise the flag");

  a_flag_needs_enable: assert property (
    !stamp_enable && !event_flag_reg |=> !event_flag_reg)
    else $error("flag rose while stamping disabled");

  a_flag_clear_drops: assert property (
    event_flag_clear && !count_event |=> !event_flag_reg)
    else $error("host clear left the flag up");

  a_flag_holds: assert property (
    !count_event && !event_flag_clear |=> $stable(event_flag_reg))
    else $error("flag changed with no event or clear");

  a_first_event_taken: assert property (
    count_event && !event_flag_reg
    |=> cap_reg.year == $past(cal_time.year) && cap_reg.date == $past(cal_time.date))
    else $error("first event was not recorded");

  // ****************************************
  // Clear and source checks
  // ****************************************
  // A clear that meets an event must still leave that event counted.
  a_clear_event_wins: assert property (
    stamp_clear_reg && count_event |=> count == 8'h01)
    else $error("event lost in the clearing cycle");

  a_clear_needs_write: assert property (
    !(ctl_write && reg_req.wdata[ETS_BIT_STAMP_CLEAR]) |=> !stamp_clear_reg)
    else $error("clear started without a write");

  // The edges are taken from the raw inputs here, not from the selected event.
  a_source_pin_counts: assert property (
    stamp_enable && !ctl_reg[ETS_BIT_SOURCE_SELECT] && pin_edge && !stamp_clear_reg
    |=> count == 8'($past(count) + 8'h01))
    else $error("pin event was not counted");

  a_source_backup_counts: assert property (
    stamp_enable && ctl_reg[ETS_BIT_SOURCE_SELECT] && backup_edge && !stamp_clear_reg
    |=> count == 8'($past(count) + 8'h01))
    else $error("switchover event was not counted");

  // ****************************************
  // Read-back checks
  // ****************************************
  // Read data is registered, so each read shows the state of its own request cycle.
  a_read_counter: assert property (
    reg_req.rd && reg_req.addr == ETS_OFS_EVENT_COUNTER |=> reg_rdata == $past(count))
    else $error("counter read-back wrong");

  a_read_seconds: assert property (
    reg_req.rd && reg_req.addr == ETS_OFS_CAPTURED_SECONDS
    |=> reg_rdata == $past(cap_reg.seconds) && !reg_rdata[ETS_BIT_SECONDS_TOP])
    else $error("seconds read-back wrong");

  a_read_clear_bit: assert property (
    reg_req.rd && reg_req.addr == ETS_OFS_EVENT_CONTROL
    |=> reg_rdata[ETS_BIT_STAMP_CLEAR] == $past(stamp_clear_reg))
    else $error("clear bit read-back wrong");

  a_read_unmapped: assert property (
    reg_req.rd && reg_req.addr > ETS_OFS_CAPTURED_SECONDS |=> reg_rdata == ETS_RST_READ_DATA)
    else $error("unmapped read returned data");

  a_read_holds: assert property (
    !reg_req.rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  c_first_capture:  cover property (capture_event && !ctl_reg[ETS_BIT_OVERWRITE_SELECT]);
  c_overwrite:      cover property (capture_event && event_flag_reg);
  c_backup_source:  cover property (count_event && ctl_reg[ETS_BIT_SOURCE_SELECT]);
  c_counter_wrap:   cover property (count_event && count == 8'hff);
  c_clear_at_event: cover property (stamp_clear_reg && count_event);

endmodule : ets_time_stamp

`default_nettype wire

// ### verification/ets_host_model.sv
// Host model that reaches the time-stamp registers through the strobe bus.
`timescale 1ns/10ps
`default_nettype none

module ets_host_model
  import ets_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic [7:0]   reg_rdata,
  output var  ets_reg_req_t reg_req
);
  // Idle bus starts quiet; after a transfer the address is inverted, and after a write the data too, so stale values never match.
  initial reg_req = '0;

  // One write: strobe held across a single sampling edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 reg_req = '{1'b1, 1'b0, a, d};
    @(posedge core_clk);
    #1 reg_req = '{1'b0, 1'b0, ~a, ~d};
  endtask : wr

  // One read: the registered answer is taken once it has landed.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1 reg_req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk);
    #1 reg_req = '{1'b0, 1'b0, ~a, 8'h5a};
    @(posedge core_clk);
    #1 d = reg_rdata;
  endtask : rd
endmodule : ets_host_model
`default_nettype wire

// ### verification/tb.sv
// Self-checking testbench for the event time-stamp capture block.
`timescale 1ns/10ps
`default_nettype none

module tb;
  import ets_pkg::*;
  localparam int CYCLE_CEIL = 20000;
  logic          core_clk;
  logic          rst;
  logic          stamp_enable;
  logic          event_input_pin;
  logic          backup_supply;
  logic          event_flag_clear;
  logic          event_flag;
  logic [7:0]    reg_rdata;
  logic [7:0]    event_counter;
  logic [7:0]    d;
  logic [7:0]    cnt_exp;
  logic          flag_exp;
  logic          src_r;
  logic          ow_r;
  logic          en_r;
  ets_reg_req_t  reg_req;
  ets_cal_time_t cal_time;
  ets_cal_time_t captured_time;
  ets_cal_time_t cap_exp;
  int            num_errors;
  int            total_checks;
  int            cycles;
  int            seed;
  logic [31:0]   r;

  ets_time_stamp dut_u (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .stamp_enable(stamp_enable), .event_input_pin(event_input_pin),
    .backup_supply(backup_supply), .cal_time(cal_time), .event_flag_clear(event_flag_clear),
    .event_flag(event_flag), .captured_time(captured_time), .event_counter(event_counter));
  ets_host_model host_u (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_req(reg_req));

  // ****************************************
  // Clock, timeout and reporting
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // A hang is cut short so the verdict is always printed.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == CYCLE_CEIL) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Expected calendar fields are built as two BCD digits.
  function automatic logic [7:0] to_bcd(input int n);
    return {4'(n / 10), 4'(n % 10)};
  endfunction : to_bcd

  // ****************************************
  // Stimulus tasks
  // ****************************************
  // Writes the control register; a clear is checked once it has had time to finish.
  task automatic ctl(input logic s, input logic o, input logic e, input logic c);
    src_r = s;
    ow_r = o;
    en_r = e;
    stamp_enable = e;
    host_u.wr(ETS_OFS_EVENT_CONTROL, {5'h00, c, o, s});
    if (c) begin
      repeat (3) @(posedge core_clk);
      #1 cnt_exp = '0;
      cap_exp = '0;
      chk(event_counter, 48'h0);
      chk(captured_time, 48'h0);
      host_u.rd(ETS_OFS_EVENT_CONTROL, d);
      chk(d, {5'h00, 1'b0, o, s});
    end
  endtask : ctl

  // Raises one source line with a fresh calendar and checks the reaction.
  task automatic fire(input logic which);
    ets_cal_time_t t;
    logic          ev;
    ev = en_r && (which == src_r);
    for (int i = 0; i < 6; i++) t[i*8 +: 8] = to_bcd({$random(seed)} % 60);
    @(posedge core_clk);
    #1 cal_time = t;
    event_input_pin = !which;
    backup_supply = which;
    repeat (2) @(posedge core_clk);
    #1 if (ev) begin
      cnt_exp++;
      if (ow_r || !flag_exp) cap_exp = t;
      flag_exp = 1'b1;
    end
    chk(event_counter, cnt_exp);
    chk(event_flag, flag_exp);
    chk(captured_time, cap_exp);
    event_input_pin = 1'b0;
    backup_supply = 1'b0;
  endtask : fire

  // Clearing the flag re-arms first-event capture.
  task automatic fclr();
    @(posedge core_clk);
    #1 event_flag_clear = 1'b1;
    @(posedge core_clk);
    #1 event_flag_clear = 1'b0;
    flag_exp = 1'b0;
    chk(event_flag, 48'h0);
  endtask : fclr

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 12;
    {rst, stamp_enable, event_input_pin, backup_supply, event_flag_clear} = 5'b10000;
    cal_time = '0;
    {cnt_exp, flag_exp, cap_exp, src_r, ow_r, en_r} = '0;
    repeat (20) @(posedge core_clk);
    #1 rst = 1'b0;
    host_u.rd(ETS_OFS_EVENT_CONTROL, d);
    chk(d, ETS_RST_EVENT_CONTROL);
    host_u.rd(ETS_OFS_EVENT_COUNTER, d);
    chk(d, 48'h0);
    host_u.rd(8'h20, d);
    chk(d, 48'h0);
    for (int k = 0; k < 300; k++) begin
      r = $random(seed);
      ctl(r[0], r[1], r[3:2] != 2'b00, r[7:4] == 4'h0);
      fire(r[8]);
      fire(r[9]);
      if (r[10]) fclr();
      if (r[11]) begin
        host_u.wr(ETS_OFS_EVENT_COUNTER, r[23:16]);
        host_u.wr(ETS_OFS_CAPTURED_SECONDS, r[31:24]);
      end
      host_u.rd(ETS_OFS_EVENT_COUNTER, d);
      chk(d, cnt_exp);
      host_u.rd(ETS_OFS_CAPTURED_SECONDS, d);
      chk(d, cap_exp.seconds);
    end
    ctl(1'b0, 1'b1, 1'b1, 1'b0);
    // Corner: an event in the clearing cycle outlives the clear; seconds top bit is dropped.
    host_u.wr(ETS_OFS_EVENT_CONTROL, {5'h00, 1'b1, 1'b1, 1'b0});
    cal_time = {8'h24, 8'h12, 8'h31, 8'h23, 8'h59, 8'hd9};
    event_input_pin = 1'b1;
    @(posedge core_clk);
    #1 chk(event_counter, 48'h1);
    chk(captured_time, 48'h24_12_31_23_59_59);
    chk(event_flag, 48'h1);
    event_input_pin = 1'b0;
    {cnt_exp, flag_exp, cap_exp} = {8'h01, 1'b1, 48'h24_12_31_23_59_59};
    // Enough back-to-back events to pass the top of the counter.
    repeat (260) fire(1'b0);
    finish_test();
  end
endmodule : tb
`default_nettype wire
